// ### hw/cpwm_pkg.sv
// Package with register map, field positions and types of the combined PWM timer block
package cpwm_pkg;
    localparam int CW = 16;
    localparam logic [3:0] OFF_MODE = 4'h0;
    localparam logic [3:0] OFF_CNT3 = 4'h1;
    localparam logic [3:0] OFF_CNT4 = 4'h2;
    localparam logic [3:0] OFF_UPLIM = 4'h3;
    localparam logic [3:0] OFF_TR1 = 4'h4;
    localparam logic [3:0] OFF_TR2 = 4'h5;
    localparam logic [3:0] OFF_TR3 = 4'h6;
    localparam logic [3:0] OFF_BUF_UPLIM = 4'h7;
    localparam logic [3:0] OFF_BUF_TR1 = 4'h8;
    localparam logic [3:0] OFF_BUF_TR2 = 4'h9;
    localparam logic [3:0] OFF_BUF_TR3 = 4'hA;
    localparam logic [3:0] OFF_OER = 4'hB;
    localparam logic [3:0] OFF_OCR = 4'hC;
    localparam logic [3:0] OFF_FLAGS = 4'hD;
    localparam logic [3:0] OFF_QCNT = 4'hE;
    localparam logic [3:0] OFF_PORT = 4'hF;
    // Mode register fields
    localparam int MODE_RUN = 0;
    localparam int MODE_CPWM = 1;
    localparam int MODE_RSPWM = 2;
    localparam int MODE_BUF = 3;
    localparam int MODE_PHASE = 4;
    localparam int MODE_CAPT = 5;
    // Output control fields
    localparam int OCR_LEVEL_SELECT_THREE = 0;
    localparam int OCR_LEVEL_SELECT_FOUR = 1;
    localparam int OCR_EXTERNAL_TRIGGER_DISABLE = 4;
    localparam logic [5:0] OER_RESET = 6'h3F;
    localparam logic [4:0] OCR_RESET = 5'h13;
    // Flag fields
    localparam int FLG_MATCHA = 0;
    localparam int FLG_OVF = 1;
    localparam int FLG_PENDING_SYNC = 3;

    typedef struct packed {
        logic [3:0] addr;
        logic [CW-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
endpackage

// ### hw/cpwm_timer.sv
// Combined complementary PWM, quadrature counter and buffered compare timer
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
module cpwm_timer (
    input wire logic clk_i,                         // 100 MHz system clock
    input wire logic rst_n_i,                       // Asynchronous reset, active low
    input wire cpwm_pkg::bus_req_s req_i,           // Register request
    output logic [cpwm_pkg::CW-1:0] rdata_o,        // Read data, cycle after read strobe
    input wire logic quadrature_input_a_i,          // Encoder phase A pin
    input wire logic quadrature_input_b_i,          // Encoder phase B pin
    input wire logic trigger_capture_i,             // Channel-one capture A event, same clock
    input wire logic capture_i,                     // Channel-three capture strobe, same clock
    output logic [5:0] pwm_o,                       // Pins: 1,1',2,2',3,3'
    output logic [5:0] pwm_oe_n_o                   // Pin output enables, low drives
);
    import cpwm_pkg::*;

    logic [5:0] mode_q;
    logic [CW-1:0] cnt3_q, cnt4_q, uplim_q, qcnt_q;
    logic [CW-1:0] gr_q [3];
    logic [CW-1:0] bufr_q [3];
    logic [CW-1:0] buf_lim_q;
    logic [5:0] oer_q, port_q, pin_q;
    logic [4:0] ocr_q;
    logic [2:0] flg_q;
    logic dir_down_q;
    logic [2:0] ph_q;
    logic [2:0] sa_q, sb_q;
    logic qa_q, qb_q;
    logic [CW-1:0] rdata_q;

    wire cpwm = mode_q[MODE_RUN] & mode_q[MODE_CPWM];
    wire rspwm = mode_q[MODE_RUN] & mode_q[MODE_RSPWM] & ~mode_q[MODE_CPWM];
    wire combined = cpwm | rspwm;
    wire wr = req_i.wr;

    // Turnarounds and matches; a register above the limit never matches
    wire lim_match = (cnt3_q == uplim_q);
    wire top_turn = cpwm & ~dir_down_q & lim_match;
    wire under4 = cpwm & dir_down_q & (cnt4_q == '0);
    wire rs_clear = rspwm & lim_match;
    logic [2:0] match;
    always_comb begin
        match[0] = combined & (cnt3_q == gr_q[0]);
        match[1] = cpwm ? (cnt4_q == gr_q[1]) : (rspwm & (cnt3_q == gr_q[1]));
        match[2] = cpwm ? (cnt4_q == gr_q[2]) : (rspwm & (cnt3_q == gr_q[2]));
    end

    // Counters: up/down pair in complementary mode, plain up counter in reset mode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt3_q <= '0;
            cnt4_q <= '0;
        end else if (wr && req_i.addr == OFF_CNT3) begin
            cnt3_q <= req_i.wdata;
        end else if (wr && req_i.addr == OFF_CNT4) begin
            cnt4_q <= req_i.wdata;
        end else if (cpwm) begin
            if (top_turn || (dir_down_q && !under4)) begin
                cnt3_q <= cnt3_q - 16'h0001;
                cnt4_q <= cnt4_q - 16'h0001;
            end else begin
                cnt3_q <= cnt3_q + 16'h0001;
                cnt4_q <= cnt4_q + 16'h0001;
            end
        end else if (rspwm) begin
            cnt3_q <= rs_clear ? '0 : cnt3_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_down_q <= 1'b0;
        end else if (!cpwm) begin
            dir_down_q <= 1'b0;
        end else if (top_turn) begin
            dir_down_q <= 1'b1;
        end else if (under4) begin
            dir_down_q <= 1'b0;
        end
    end

    // Buffer transfer moments per mode
    wire buf_on = mode_q[MODE_BUF];
    wire xfer_turn = buf_on & (top_turn | under4);
    wire xfer_rs = buf_on & rs_clear;
    wire capt = buf_on & mode_q[MODE_CAPT] & capture_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            uplim_q <= 16'hFFFF;
        end else if (capt) begin
            uplim_q <= cnt3_q;
        end else if (xfer_turn || xfer_rs) begin
            uplim_q <= buf_lim_q;
        end else if (wr && req_i.addr == OFF_UPLIM) begin
            uplim_q <= req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buf_lim_q <= 16'hFFFF;
        end else if (capt) begin
            buf_lim_q <= uplim_q;
        end else if (wr && req_i.addr == OFF_BUF_UPLIM) begin
            buf_lim_q <= req_i.wdata;
        end
    end

    // Transition registers and their buffers, channels three and four only
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_tr
            wire [3:0] gr_off = OFF_TR1 + 4'(g);
            wire [3:0] br_off = OFF_BUF_TR1 + 4'(g);
            wire own = buf_on & ~combined & mode_q[MODE_RUN] & (cnt3_q == gr_q[g]);
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    gr_q[g] <= 16'hFFFF;
                end else if (xfer_turn || xfer_rs || own) begin
                    gr_q[g] <= bufr_q[g];
                end else if (wr && req_i.addr == gr_off) begin
                    gr_q[g] <= req_i.wdata;
                end
            end
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    bufr_q[g] <= 16'hFFFF;
                end else if (wr && req_i.addr == br_off) begin
                    bufr_q[g] <= req_i.wdata;
                end
            end
            // Each pair toggles at its match; reset mode clears all at the clear
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ph_q[g] <= 1'b0;
                end else if (!combined) begin
                    ph_q[g] <= 1'b0;
                end else if (rs_clear) begin
                    ph_q[g] <= 1'b0;
                end else if (match[g]) begin
                    ph_q[g] <= ~ph_q[g];
                end
            end
        end
    endgenerate

    // Flags: hardware set wins over a software clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flg_q <= '0;
        end else begin
            if (top_turn || rs_clear) begin
                flg_q[FLG_MATCHA] <= 1'b1;
            end else if (wr && req_i.addr == OFF_FLAGS && !req_i.wdata[FLG_MATCHA]) begin
                flg_q[FLG_MATCHA] <= 1'b0;
            end
            if (under4) begin
                flg_q[FLG_OVF] <= 1'b1;
            end else if (wr && req_i.addr == OFF_FLAGS && !req_i.wdata[FLG_OVF]) begin
                flg_q[FLG_OVF] <= 1'b0;
            end
            flg_q[2] <= dir_down_q;
        end
    end

    // Mode, output control and port data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= '0;
            ocr_q <= OCR_RESET;
            port_q <= '0;
        end else if (wr) begin
            if (req_i.addr == OFF_MODE) mode_q <= req_i.wdata[5:0];
            if (req_i.addr == OFF_OCR) ocr_q <= req_i.wdata[4:0];
            if (req_i.addr == OFF_PORT) port_q <= req_i.wdata[5:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oer_q <= OER_RESET;
        end else if (combined && !ocr_q[OCR_EXTERNAL_TRIGGER_DISABLE] && trigger_capture_i) begin
            oer_q <= '0;
        end else if (wr && req_i.addr == OFF_OER) begin
            oer_q <= req_i.wdata[5:0];
        end
    end

    // Pin drive: complementary pairs, level select, enable fallback
    logic [5:0] timer_lvl;
    always_comb begin
        timer_lvl[0] = ph_q[0] ^ ~ocr_q[OCR_LEVEL_SELECT_THREE];
        timer_lvl[1] = ~ph_q[0] ^ ~ocr_q[OCR_LEVEL_SELECT_THREE];
        timer_lvl[2] = ph_q[1] ^ ~ocr_q[OCR_LEVEL_SELECT_FOUR];
        timer_lvl[3] = ~ph_q[1] ^ ~ocr_q[OCR_LEVEL_SELECT_FOUR];
        timer_lvl[4] = ph_q[2] ^ ~ocr_q[OCR_LEVEL_SELECT_FOUR];
        timer_lvl[5] = ~ph_q[2] ^ ~ocr_q[OCR_LEVEL_SELECT_FOUR];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_q <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                pin_q[i] <= (combined && oer_q[i]) ? timer_lvl[i] : port_q[i];
            end
        end
    end
    assign pwm_o = pin_q;
    assign pwm_oe_n_o = '0;

    // Quadrature inputs: three stages, change accepted when stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sa_q <= '0;
            sb_q <= '0;
            qa_q <= 1'b0;
            qb_q <= 1'b0;
        end else begin
            sa_q <= {sa_q[1:0], quadrature_input_a_i};
            sb_q <= {sb_q[1:0], quadrature_input_b_i};
            if (sa_q[1] == sa_q[2]) qa_q <= sa_q[2];
            if (sb_q[1] == sb_q[2]) qb_q <= sb_q[2];
        end
    end

    wire a_now = (sa_q[1] == sa_q[2]) ? sa_q[2] : qa_q;
    wire b_now = (sb_q[1] == sb_q[2]) ? sb_q[2] : qb_q;
    wire a_edge = a_now ^ qa_q;
    wire b_edge = b_now ^ qb_q;
    // Up when the edge moves the pair one step forward in the 00,01,11,10 order
    wire q_up = (b_edge & (b_now ^ a_now)) | (a_edge & ~(a_now ^ b_now));
    wire q_dn = (b_edge & ~(b_now ^ a_now)) | (a_edge & (a_now ^ b_now));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            qcnt_q <= '0;
        end else if (wr && req_i.addr == OFF_QCNT) begin
            qcnt_q <= req_i.wdata;
        end else if (mode_q[MODE_PHASE] && !(a_edge && b_edge)) begin
            if (q_up) qcnt_q <= qcnt_q + 16'h0001;
            else if (q_dn) qcnt_q <= qcnt_q - 16'h0001;
        end
    end

    // Register read port
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (req_i.rd) begin
            case (req_i.addr)
                OFF_MODE: rdata_q <= {10'h000, mode_q};
                OFF_CNT3: rdata_q <= cnt3_q;
                OFF_CNT4: rdata_q <= cnt4_q;
                OFF_UPLIM: rdata_q <= uplim_q;
                OFF_TR1: rdata_q <= gr_q[0];
                OFF_TR2: rdata_q <= gr_q[1];
                OFF_TR3: rdata_q <= gr_q[2];
                OFF_BUF_UPLIM: rdata_q <= buf_lim_q;
                OFF_BUF_TR1: rdata_q <= bufr_q[0];
                OFF_BUF_TR2: rdata_q <= bufr_q[1];
                OFF_BUF_TR3: rdata_q <= bufr_q[2];
                OFF_OER: rdata_q <= {10'h000, oer_q};
                OFF_OCR: rdata_q <= {11'h000, ocr_q};
                OFF_FLAGS: rdata_q <= {13'h0, flg_q};
                OFF_QCNT: rdata_q <= qcnt_q;
                OFF_PORT: rdata_q <= {10'h000, port_q};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end
    assign rdata_o = rdata_q;

    chk_turn_down: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        top_turn && !wr |=> dir_down_q) else $error("no down turn at limit");
    chk_under_up: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        under4 && !wr && cpwm |=> !dir_down_q) else $error("no up turn at underflow");
    chk_flag_up: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(flg_q[FLG_MATCHA]) |-> $past(!dir_down_q)) else $error("match flag while down");
    chk_ovf_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        under4 |=> flg_q[FLG_OVF]) else $error("overflow flag missed");
    chk_buf_xfer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        xfer_turn |=> gr_q[0] == $past(bufr_q[0])) else $error("buffer not copied");
    chk_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cpwm && match[1] && $past(cpwm) |=> ph_q[1] != $past(ph_q[1])) else $error("no toggle");
    chk_trig_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        combined && !ocr_q[OCR_EXTERNAL_TRIGGER_DISABLE] && trigger_capture_i |=> oer_q == '0)
        else $error("trigger did not disable");
    chk_port_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !oer_q[0] |=> pwm_o[0] == $past(port_q[0])) else $error("pin not from port");
    chk_capt_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        capt |=> uplim_q == $past(cnt3_q) && buf_lim_q == $past(uplim_q))
        else $error("capture swap wrong");

    // Quadrature steps move the count by exactly one
    chk_quad_up: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_q[MODE_PHASE] && q_up && !(a_edge && b_edge) && !(wr && req_i.addr == OFF_QCNT)
        |=> qcnt_q == $past(qcnt_q) + 16'h0001) else $error("quadrature up step lost");
    chk_quad_down: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_q[MODE_PHASE] && q_dn && !(a_edge && b_edge) && !(wr && req_i.addr == OFF_QCNT)
        |=> qcnt_q == $past(qcnt_q) - 16'h0001) else $error("quadrature down step lost");
    chk_pair_comp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        combined && oer_q[1:0] == 2'b11 |=> pwm_o[0] != pwm_o[1])
        else $error("pair one not complementary");
    chk_level_inv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        combined && oer_q[0] |=> pwm_o[0] == ($past(ph_q[0]) == $past(ocr_q[OCR_LEVEL_SELECT_THREE])))
        else $error("level select not applied");
    chk_own_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        buf_on && !combined && mode_q[MODE_RUN] && cnt3_q == gr_q[0]
        |=> gr_q[0] == $past(bufr_q[0])) else $error("own match copy missed");
    chk_rs_xfer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        xfer_rs && !capt |=> gr_q[2] == $past(bufr_q[2]) && uplim_q == $past(buf_lim_q))
        else $error("reset mode transfer missed");
    cov_turn: cover property (@(posedge clk_i) disable iff (!rst_n_i) top_turn ##[1:300] under4);
    cov_trig: cover property (@(posedge clk_i) disable iff (!rst_n_i) combined && trigger_capture_i);
    cov_quad: cover property (@(posedge clk_i) disable iff (!rst_n_i) mode_q[MODE_PHASE] && q_dn);
    cov_rs_xfer: cover property (@(posedge clk_i) disable iff (!rst_n_i) xfer_rs);
endmodule

// ### tb/enc_stage.sv
// Partner model: quadrature encoder source and power-stage gate receiver
`timescale 1ns/10ps
module enc_stage (
    input wire logic clk_i,        // System clock
    input wire logic step_i,       // Advance the encoder by one edge
    input wire logic dir_up_i,     // Step direction, 1 counts up
    input wire logic [5:0] pwm_i,  // Timer pin drive values
    input wire logic [5:0] oe_n_i, // Timer pin enables, low drives
    output logic enc_a_o,          // Encoder phase A
    output logic enc_b_o,          // Encoder phase B
    output logic [5:0] pin_o       // Gate levels seen by the power stage
);
    logic [1:0] pos_q = 2'h0;

    // Gray walk of (A,B) 00,01,11,10 is forward; one edge per step and the bench
    // spaces steps six states apart, above the minimum width and phase offset
    always_ff @(posedge clk_i) begin
        if (step_i) begin
            pos_q <= dir_up_i ? pos_q + 2'h1 : pos_q - 2'h1;
        end
    end
    assign enc_a_o = pos_q[1];
    assign enc_b_o = pos_q[1] ^ pos_q[0];
    // Gate inputs carry pull-downs, so an undriven line reads low
    assign pin_o = pwm_i & ~oe_n_i;
endmodule

// ### tb/testbench.sv
// Self-checking bench for the combined PWM timer
`timescale 1ns/10ps
module testbench;
    import cpwm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    bus_req_s req_q = '0;
    logic [CW-1:0] rdata;
    logic trig_q = 1'b0;
    logic capt_q = 1'b0;
    logic step_q = 1'b0;
    logic up_q = 1'b1;
    logic enc_a;
    logic enc_b;
    logic [5:0] pwm;
    logic [5:0] oe_n;
    logic [5:0] pin;
    logic [5:0] last;
    logic [5:0] p0;
    logic [CW-1:0] d;
    logic [CW-1:0] v;
    logic [CW-1:0] prev;
    logic [31:0] r;
    int n_fail = 0;
    int total_checks = 0;
    integer seed = 32'h910b;
    int cyc = 0;
    int qcnt = 0;
    int tq0[$];
    int tq2[$];
    int tq4[$];

    cpwm_timer i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_q), .rdata_o(rdata),
        .quadrature_input_a_i(enc_a), .quadrature_input_b_i(enc_b),
        .trigger_capture_i(trig_q), .capture_i(capt_q), .pwm_o(pwm), .pwm_oe_n_o(oe_n));
    enc_stage i_enc (.clk_i(clk_i), .step_i(step_q), .dir_up_i(up_q), .pwm_i(pwm),
        .oe_n_i(oe_n), .enc_a_o(enc_a), .enc_b_o(enc_b), .pin_o(pin));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Cycle stamps of every gate edge on pins 1, 2 and 3, one pin of each pair
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        last <= pin;
        if (pin[0] !== last[0]) tq0.push_back(cyc);
        if (pin[2] !== last[2]) tq2.push_back(cyc);
        if (pin[4] !== last[4]) tq4.push_back(cyc);
    end

    task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [CW-1:0] val);
        @(posedge clk_i);
        req_q <= '{addr: a, wdata: val, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req_q.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [CW-1:0] val);
        @(posedge clk_i);
        req_q <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req_q.rd <= 1'b0;
        #1 val = rdata;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [CW-1:0] exp);
        logic [CW-1:0] val;
        rd(a, val);
        check(val, exp);
    endtask

    task automatic pulse_trig();
        @(posedge clk_i);
        trig_q <= 1'b1;
        @(posedge clk_i);
        trig_q <= 1'b0;
    endtask

    task automatic summarize();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        $display("[FAIL] %0t run did not finish", $time);
        summarize();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rchk(OFF_OER, 16'h003F);
        rchk(OFF_OCR, 16'h0013);
        // Quadrature walk with random direction, one edge every six states
        wr(OFF_MODE, 16'h0011);
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            up_q <= r[0];
            step_q <= 1'b1;
            qcnt += r[0] ? 1 : -1;
            @(posedge clk_i);
            step_q <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
        rchk(OFF_QCNT, CW'(qcnt));
        // Complementary run: margin 3, limit 23, pair one parked above the limit
        wr(OFF_MODE, 16'h0000);
        wr(OFF_CNT3, 16'h0003);
        wr(OFF_CNT4, 16'h0000);
        wr(OFF_UPLIM, 16'h0017);
        wr(OFF_TR1, 16'h0030);
        wr(OFF_TR2, 16'h000A);
        wr(OFF_TR3, 16'h000E);
        wr(OFF_MODE, 16'h0003);
        repeat (20) @(posedge clk_i);
        tq0.delete();
        tq2.delete();
        tq4.delete();
        p0 = pin;
        repeat (150) @(posedge clk_i);
        check(CW'(tq0.size()), 16'h0000);
        check(CW'(pin[0] ^ pin[1]), 16'h0001);
        check(CW'(pin[2] ^ pin[3]), 16'h0001);
        check(CW'(oe_n), 16'h0000);
        for (int k = 0; k < 4; k++) begin
            check(CW'(tq2[k+1] - tq2[k]), 16'h0014);
            check(CW'(tq4[k+2] - tq4[k]), 16'h0028);
        end
        check(CW'((tq4[1] - tq4[0]) * (tq4[2] - tq4[1])), 16'h0150);
        rd(OFF_FLAGS, d);
        check(d & 16'h0003, 16'h0003);
        // Level select cleared inverts the parked pair
        wr(OFF_OCR, 16'h0010);
        repeat (3) @(posedge clk_i);
        check(CW'(pin[0]), CW'(!p0[0]));
        // Cleared enable bit hands pin 1 to port data
        wr(OFF_OER, 16'h003E);
        for (int b = 0; b < 2; b++) begin
            wr(OFF_PORT, CW'(b));
            repeat (3) @(posedge clk_i);
            check(CW'(pin[0]), CW'(b));
        end
        // Trigger capture ignored while disabled, then clears all enables
        pulse_trig();
        rchk(OFF_OER, 16'h003E);
        wr(OFF_OCR, 16'h0003);
        wr(OFF_PORT, 16'h002A);
        pulse_trig();
        rchk(OFF_OER, 16'h0000);
        repeat (3) @(posedge clk_i);
        check(CW'(pin), 16'h002A);
        wr(OFF_MODE, 16'h0000);
        wr(OFF_FLAGS, 16'h0000);
        rd(OFF_FLAGS, d);
        check(d & 16'h0003, 16'h0000);
        // Buffered transfers in complementary and reset-synchronized modes
        // Limit buffer holds the same limit so the turnarounds keep their period
        wr(OFF_BUF_UPLIM, 16'h0017);
        prev = 16'h000E;
        for (int m = 0; m < 2; m++) begin
            wr(OFF_MODE, 16'h0000);
            wr(OFF_CNT3, 16'h0003);
            wr(OFF_CNT4, 16'h0000);
            v = (CW'($random(seed)) & 16'h000F) | 16'h0004;
            wr(OFF_BUF_TR3, v);
            wr(OFF_MODE, m ? 16'h000D : 16'h000B);
            rchk(OFF_TR3, prev);
            repeat (60) @(posedge clk_i);
            rchk(OFF_TR3, v);
            prev = v;
        end
        // Compare buffering copies at the register's own match
        wr(OFF_MODE, 16'h0000);
        wr(OFF_CNT3, 16'h0000);
        wr(OFF_TR1, 16'h0005);
        wr(OFF_BUF_TR1, 16'h0077);
        wr(OFF_MODE, 16'h0009);
        rchk(OFF_TR1, 16'h0005);
        // Counter is idle outside combined modes, so preset it onto the match
        wr(OFF_CNT3, 16'h0005);
        rchk(OFF_TR1, 16'h0077);
        // Capture buffering: counter into register, old register into buffer
        wr(OFF_MODE, 16'h0028);
        wr(OFF_UPLIM, 16'h1111);
        v = CW'($random(seed));
        wr(OFF_CNT3, v);
        @(posedge clk_i);
        capt_q <= 1'b1;
        @(posedge clk_i);
        capt_q <= 1'b0;
        rchk(OFF_UPLIM, v);
        rchk(OFF_BUF_UPLIM, 16'h1111);
        summarize();
    end
endmodule
